// >>> rtl/scf_pkg.sv
// Constants, types and shared decode functions for the serial port control flags block.
package scf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; the APB byte address is four times the index.
   localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
   localparam logic [9:0] IDX_SERIAL1_CONTROL = 10'h0f8;
   localparam logic [9:0] IDX_SERIAL0_VIEW = 10'h098;
   localparam logic [9:0] IDX_UART1_EXT = 10'h0c4;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h100;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h101;
   localparam logic [9:0] IDX_ADDR_CFG = 10'h102;

   ////////////////////////////////////////////////////////////////////////////
   // Bit positions inside the control byte of either port.
   localparam int B_MODE_HI = 7;
   localparam int B_MODE_LO = 6;
   localparam int B_FILTER = 5;
   localparam int B_REN = 4;
   localparam int B_TB8 = 3;
   localparam int B_RB8 = 2;
   localparam int B_TI = 1;
   localparam int B_RI = 0;

   // Bit positions in power_control and in the port-1 extension register.
   localparam int B_BAUD_DOUBLE = 7;
   localparam int B_FE_SELECT = 6;
   localparam int B_PC_RSVD = 5;
   localparam int B_INT_EN1 = 0;

   // Interrupt status and mask layout.
   localparam int B_IRQ_TX1 = 0;
   localparam int B_IRQ_RX1 = 1;
   localparam int B_IRQ_FE1 = 2;
   localparam int B_IRQ_FE0 = 3;
   localparam int IRQ_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic [7:0] RST_ADDR_MASK = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Bit rate divisors of port 1, as terminal counts of a 7-bit counter.
   localparam logic [6:0] T3_DIV_LAST = 7'h0f;
   localparam logic [6:0] M2_SLOW_LAST = 7'h3f;
   localparam logic [6:0] M2_FAST_LAST = 7'h1f;
   localparam logic [6:0] M0_LAST = 7'h0b;

   typedef enum logic [1:0] {
      SCF_MODE0 = 2'b00,
      SCF_MODE1 = 2'b01,
      SCF_MODE2 = 2'b10,
      SCF_MODE3 = 2'b11
   } scf_mode_t;

   // Modes 2 and 3 carry a ninth data bit.
   function automatic logic has_ninth(input scf_mode_t m);
      return m[1];
   endfunction

   // Modes 1 and 3 take their bit clock from a timer overflow.
   function automatic logic timer_clocked(input scf_mode_t m);
      return m[0];
   endfunction

endpackage

// >>> rtl/scf_rx_accept.sv
// Receive acceptance filter of port 1: multiprocessor address and stop bit checks.
`timescale 1ns/1ps
`default_nettype none
module scf_rx_accept (
   // Configuration
   input wire scf_pkg::scf_mode_t mode,
   input wire logic filter,
   input wire logic [7:0] given_addr,
   input wire logic [7:0] addr_mask,
   // Received frame
   input wire logic [7:0] rx_data,
   input wire logic rx_bit9,
   // Decision
   output logic accept
);

   logic [7:0] bcast_addr;
   logic addr_hit;

   // Don't-care bits of the mask widen the given address and are forced to 1 in the exactly matched broadcast address.
   assign bcast_addr = given_addr | addr_mask;

   always_comb begin
      addr_hit = ((rx_data & ~addr_mask) == (given_addr & ~addr_mask)) || (rx_data == bcast_addr);
      case (mode)
         // R2: filter inert
         scf_pkg::SCF_MODE0: accept = 1'b1;
         // R3: stop bit and address
         scf_pkg::SCF_MODE1: accept = !filter || (rx_bit9 && addr_hit);
         // R4: ninth bit and address
         scf_pkg::SCF_MODE2,
         scf_pkg::SCF_MODE3: accept = !filter || (rx_bit9 && addr_hit);
         default: accept = 1'b0;
      endcase
   end

endmodule
`default_nettype wire

// >>> rtl/scf_top.sv
// Control and status flags of serial port 1, plus port-0 baud and frame-error access bits.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: With port-1 select high, bit 7 is a frame-error flag, set by hardware only.
// R2: The port-1 filter bit has no effect in mode 0.
// R3: Mode 1 with filter: accept only stop bit 1 and matching address.
// R4: Modes 2/3 with filter: accept only ninth bit 1 and matching address.
// R5: Receive enable gates reception; mode 0 also needs receive-done clear.
// R6: Ninth transmit bit is sent in modes 2 and 3, ignored otherwise.
// R7: Ninth receive bit takes ninth bit (modes 2/3) or stop level (mode 1).
// R8: Transmit-done set at end of each transmitted frame.
// R9: Receive-done set at frame end, subject to the filter condition.
// R10: Enabled port-1 interrupt requests service while either done flag is set.
// R11: Software clears the done flags; hardware never clears them.
// R12: Port-0 baud double doubles mode 2 and timer-1 clocked modes 1/3.
// R13: Port-0 select steers bit 7 between mode bit and frame-error flag.
// R14: Port-1 select steers bit 7 between mode bit and frame-error flag.
// R15: Port-1 baud double doubles the mode 2 bit rate.
// R16: Port-1 modes 1 and 3 tick once per sixteen timer-3 overflows.
// R17: Stop bit sampled low sets the frame-error flag regardless of view; port 1 sets it only in mode 1.
module scf_top (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Port-1 shift engine events
   input wire logic tx1_frame_done,
   input wire logic rx1_frame_done,
   input wire logic [7:0] rx1_data,
   input wire logic rx1_bit9,
   input wire logic timer3_ovf,
   // Port-1 controls to the shift engines
   output logic [1:0] uart1_mode,
   output logic uart1_rx_enable,
   output logic uart1_tx_ninth,
   output logic uart1_baud_tick,
   output logic uart1_service_req,
   // Port-0 events and controls
   input wire logic uart0_frame_err_evt,
   input wire logic uart0_timer1_src,
   output logic [1:0] uart0_mode,
   output logic uart0_rate_x2,
   // Interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // State.
   localparam int IRQ_W_L = scf_pkg::IRQ_W;
   logic [6:0] ctl1_r, ctl1_nxt;
   logic mode_hi1_r, mode_hi1_nxt;
   logic fe1_r, fe1_nxt;
   logic mode_hi0_r, mode_hi0_nxt;
   logic mode_lo0_r, mode_lo0_nxt;
   logic fe0_r, fe0_nxt;
   logic [7:0] power_control_r, power_control_nxt;
   logic [7:0] ext1_r, ext1_nxt;
   logic [IRQ_W_L-1:0] irq_stat_r, irq_stat_nxt;
   logic [IRQ_W_L-1:0] irq_mask_r, irq_mask_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [7:0] amask_r, amask_nxt;
   logic [6:0] baud_cnt_r, baud_cnt_nxt;
   logic baud_tick_r, baud_tick_nxt;
   logic [31:0] prdata_r, prdata_nxt;


   scf_pkg::scf_mode_t mode1;
   scf_pkg::scf_mode_t mode0;
   logic [9:0] idx;
   logic wr_acc;
   logic wr_b0;
   logic wr_b1;
   logic mapped;
   logic accept;
   logic rx_async_end;
   logic rx_mode0_end;
   logic rx_taken;
   logic frame_err1;
   logic [6:0] baud_last;
   logic baud_step;

   assign mode1 = scf_pkg::scf_mode_t'({mode_hi1_r, ctl1_r[scf_pkg::B_MODE_LO]});
   assign mode0 = scf_pkg::scf_mode_t'({mode_hi0_r, mode_lo0_r});
   assign idx = paddr[11:2];
   assign wr_acc = psel && penable && pwrite;
   assign wr_b0 = wr_acc && pstrb[0];
   assign wr_b1 = wr_acc && pstrb[1];

   scf_rx_accept u_accept (
      .mode(mode1),
      .filter(ctl1_r[scf_pkg::B_FILTER]),
      .given_addr(addr_r),
      .addr_mask(amask_r),
      .rx_data(rx1_data),
      .rx_bit9(rx1_bit9),
      .accept(accept)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Frame events.
   assign rx_mode0_end = rx1_frame_done && (mode1 == scf_pkg::SCF_MODE0);
   assign rx_async_end = rx1_frame_done && (mode1 != scf_pkg::SCF_MODE0);
   // R9: filtered completion
   assign rx_taken = rx_mode0_end || (rx_async_end && accept);
   // R17: stop bit low
   assign frame_err1 = rx_async_end && !rx1_bit9 && !scf_pkg::has_ninth(mode1);

   ////////////////////////////////////////////////////////////////////////////
   // Register file next state; hardware sets are applied last so they win.
   always_comb begin
      ctl1_nxt = ctl1_r;
      mode_hi1_nxt = mode_hi1_r;
      fe1_nxt = fe1_r;
      mode_hi0_nxt = mode_hi0_r;
      mode_lo0_nxt = mode_lo0_r;
      fe0_nxt = fe0_r;
      power_control_nxt = power_control_r;
      ext1_nxt = ext1_r;
      irq_stat_nxt = irq_stat_r;
      irq_mask_nxt = irq_mask_r;
      addr_nxt = addr_r;
      amask_nxt = amask_r;
      if (wr_b0) begin
         case (idx)
            scf_pkg::IDX_SERIAL1_CONTROL: begin
               // R14: bit 7 steering
               if (ext1_r[scf_pkg::B_FE_SELECT]) begin
                  // R1: software may only clear
                  if (!pwdata[7]) begin
                     fe1_nxt = 1'b0;
                  end
               end else begin
                  mode_hi1_nxt = pwdata[7];
               end
               ctl1_nxt = pwdata[6:0];
            end
            scf_pkg::IDX_SERIAL0_VIEW: begin
               // R13: bit 7 steering
               if (power_control_r[scf_pkg::B_FE_SELECT]) begin
                  if (!pwdata[7]) begin
                     fe0_nxt = 1'b0;
                  end
               end else begin
                  mode_hi0_nxt = pwdata[7];
               end
               mode_lo0_nxt = pwdata[6];
            end
            scf_pkg::IDX_POWER_CONTROL: begin
               power_control_nxt = pwdata[7:0];
               power_control_nxt[scf_pkg::B_PC_RSVD] = 1'b0;
            end
            scf_pkg::IDX_UART1_EXT: begin
               ext1_nxt = pwdata[7:0] & 8'hc1;
            end
            scf_pkg::IDX_IRQ_STATUS: begin
               irq_stat_nxt = irq_stat_r & ~pwdata[IRQ_W_L-1:0];
            end
            scf_pkg::IDX_IRQ_MASK: begin
               irq_mask_nxt = pwdata[IRQ_W_L-1:0];
            end
            scf_pkg::IDX_ADDR_CFG: begin
               addr_nxt = pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
      if (wr_b1 && idx == scf_pkg::IDX_ADDR_CFG) begin
         amask_nxt = pwdata[15:8];
      end
      // R8: transmit done
      if (tx1_frame_done) begin
         ctl1_nxt[scf_pkg::B_TI] = 1'b1;
         irq_stat_nxt[scf_pkg::B_IRQ_TX1] = 1'b1;
      end
      if (rx_taken) begin
         ctl1_nxt[scf_pkg::B_RI] = 1'b1;
         irq_stat_nxt[scf_pkg::B_IRQ_RX1] = 1'b1;
      end
      // R7: ninth bit or stop level
      if (rx_async_end && accept) begin
         ctl1_nxt[scf_pkg::B_RB8] = rx1_bit9;
      end
      // R17: set regardless of view
      if (frame_err1) begin
         fe1_nxt = 1'b1;
         irq_stat_nxt[scf_pkg::B_IRQ_FE1] = 1'b1;
      end
      if (uart0_frame_err_evt) begin
         fe0_nxt = 1'b1;
         irq_stat_nxt[scf_pkg::B_IRQ_FE0] = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl1_r <= scf_pkg::RST_BYTE[6:0];
         mode_hi1_r <= 1'b0;
         fe1_r <= 1'b0;
         mode_hi0_r <= 1'b0;
         mode_lo0_r <= 1'b0;
         fe0_r <= 1'b0;
         power_control_r <= scf_pkg::RST_BYTE;
         ext1_r <= scf_pkg::RST_BYTE;
         irq_stat_r <= scf_pkg::RST_IRQ;
         irq_mask_r <= scf_pkg::RST_IRQ;
         addr_r <= scf_pkg::RST_ADDR;
         amask_r <= scf_pkg::RST_ADDR_MASK;
      end else begin
         ctl1_r <= ctl1_nxt;
         mode_hi1_r <= mode_hi1_nxt;
         fe1_r <= fe1_nxt;
         mode_hi0_r <= mode_hi0_nxt;
         mode_lo0_r <= mode_lo0_nxt;
         fe0_r <= fe0_nxt;
         power_control_r <= power_control_nxt;
         ext1_r <= ext1_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         addr_r <= addr_nxt;
         amask_r <= amask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port-1 bit rate tick. The counter restarts on wrap only, so a mode change
   // mid-period lengthens or shortens one period; software changes mode between frames.
   always_comb begin
      case (mode1)
         scf_pkg::SCF_MODE0: baud_last = scf_pkg::M0_LAST;
         // R15: doubled mode 2
         scf_pkg::SCF_MODE2: baud_last = ext1_r[scf_pkg::B_BAUD_DOUBLE] ?
                                         scf_pkg::M2_FAST_LAST : scf_pkg::M2_SLOW_LAST;
         // R16: sixteen overflows
         scf_pkg::SCF_MODE1,
         scf_pkg::SCF_MODE3: baud_last = scf_pkg::T3_DIV_LAST;
         default: baud_last = scf_pkg::M0_LAST;
      endcase
      baud_step = scf_pkg::timer_clocked(mode1) ? timer3_ovf : 1'b1;
      baud_cnt_nxt = baud_cnt_r;
      baud_tick_nxt = 1'b0;
      if (baud_step) begin
         if (baud_cnt_r >= baud_last) begin
            baud_cnt_nxt = 7'h00;
            baud_tick_nxt = 1'b1;
         end else begin
            baud_cnt_nxt = baud_cnt_r + 7'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         baud_cnt_r <= 7'h00;
         baud_tick_r <= 1'b0;
      end else begin
         baud_cnt_r <= baud_cnt_nxt;
         baud_tick_r <= baud_tick_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read data, captured in the setup cycle; the access phase never waits.
   always_comb begin
      prdata_nxt = prdata_r;
      mapped = 1'b1;
      case (idx)
         scf_pkg::IDX_SERIAL1_CONTROL: begin
            prdata_nxt = {24'h000000,
                          (ext1_r[scf_pkg::B_FE_SELECT] ? fe1_r : mode_hi1_r), ctl1_r};
         end
         scf_pkg::IDX_SERIAL0_VIEW: begin
            prdata_nxt = {24'h000000,
                          (power_control_r[scf_pkg::B_FE_SELECT] ? fe0_r : mode_hi0_r),
                          mode_lo0_r, 6'h00};
         end
         scf_pkg::IDX_POWER_CONTROL: prdata_nxt = {24'h000000, power_control_r};
         scf_pkg::IDX_UART1_EXT: prdata_nxt = {24'h000000, ext1_r};
         scf_pkg::IDX_IRQ_STATUS: prdata_nxt = {28'h0000000, irq_stat_r};
         scf_pkg::IDX_IRQ_MASK: prdata_nxt = {28'h0000000, irq_mask_r};
         scf_pkg::IDX_ADDR_CFG: prdata_nxt = {16'h0000, amask_r, addr_r};
         default: begin
            prdata_nxt = 32'h00000000;
            mapped = 1'b0;
         end
      endcase
      if (!(psel && !penable)) begin
         prdata_nxt = prdata_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_r <= 32'h00000000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped;

   ////////////////////////////////////////////////////////////////////////////
   // Controls to the engines.
   assign uart1_mode = mode1;
   // R5: reception gate
   assign uart1_rx_enable = ctl1_r[scf_pkg::B_REN] &&
                            ((mode1 != scf_pkg::SCF_MODE0) || !ctl1_r[scf_pkg::B_RI]);
   // R6: ninth transmit bit
   assign uart1_tx_ninth = scf_pkg::has_ninth(mode1) && ctl1_r[scf_pkg::B_TB8];
   assign uart1_baud_tick = baud_tick_r;
   // R10: service request
   assign uart1_service_req = ext1_r[scf_pkg::B_INT_EN1] &&
                              (ctl1_r[scf_pkg::B_TI] || ctl1_r[scf_pkg::B_RI]);
   assign uart0_mode = mode0;
   // R12: port-0 doubling
   assign uart0_rate_x2 = power_control_r[scf_pkg::B_BAUD_DOUBLE] &&
                          ((mode0 == scf_pkg::SCF_MODE2) ||
                           (scf_pkg::timer_clocked(mode0) && uart0_timer1_src));
   assign irq = |(irq_stat_r & irq_mask_r);

endmodule
`default_nettype wire

// >>> testbench/scf_node.sv
// Model of the shift engines and timer that report frame events to the block.
`timescale 1ns/1ps
`default_nettype none
module scf_node (
   // Clock
   input wire logic clk,
   // Events
   output logic tx1_frame_done,
   output logic rx1_frame_done,
   output logic [7:0] rx1_data,
   output logic rx1_bit9,
   output logic timer3_ovf,
   output logic uart0_frame_err_evt
);
   logic [1:0] div;
   initial begin
      {tx1_frame_done, rx1_frame_done, rx1_data, rx1_bit9} = '0;
      {timer3_ovf, uart0_frame_err_evt, div} = '0;
   end
   always @(posedge clk) begin
      div <= div + 2'h1;
      timer3_ovf <= div == 2'h3;
   end
   task automatic send(input logic [7:0] d, input logic b9);
      @(posedge clk);
      rx1_frame_done <= 1'b1;
      rx1_data <= d;
      rx1_bit9 <= b9;
      @(posedge clk);
      rx1_frame_done <= 1'b0;
      rx1_data <= ~d;
      rx1_bit9 <= ~b9;
   endtask
   task automatic sent(input logic port0);
      @(posedge clk);
      tx1_frame_done <= !port0;
      uart0_frame_err_evt <= port0;
      @(posedge clk);
      tx1_frame_done <= 1'b0;
      uart0_frame_err_evt <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> testbench/scf_properties.sv
// Port-level properties of the serial port control flags block.
`timescale 1ns/1ps
`default_nettype none
module scf_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   // Events
   input wire logic tx1_frame_done,
   input wire logic rx1_frame_done,
   input wire logic timer3_ovf,
   input wire logic uart0_timer1_src,
   // Controls
   input wire logic [1:0] uart1_mode,
   input wire logic [1:0] uart0_mode,
   input wire logic uart1_tx_ninth,
   input wire logic uart1_baud_tick,
   input wire logic uart1_service_req,
   input wire logic uart0_rate_x2,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [6:0] gap_r, gap_nxt;
   logic [4:0] ovf_r, ovf_nxt;
   logic [1:0] mode_r;
   logic same_r, same_nxt, wr;
   // An interval in which the mode changed proves nothing about the divider.
   always_comb begin
      wr = psel && penable && pwrite;
      same_nxt = (uart1_mode == mode_r) && (uart1_baud_tick || same_r);
      gap_nxt = uart1_baud_tick ? 7'h00 : gap_r + {6'h00, gap_r != 7'h7f};
      ovf_nxt = uart1_baud_tick ? {4'h0, timer3_ovf} : ovf_r + {4'h0, timer3_ovf && ovf_r != 5'h1f};
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gap_r <= 7'h00;
         ovf_r <= 5'h00;
         mode_r <= 2'h0;
         same_r <= 1'b0;
      end else begin
         gap_r <= gap_nxt;
         ovf_r <= ovf_nxt;
         mode_r <= uart1_mode;
         same_r <= same_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_ready;
      psel && penable |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready missing in access");
   property p_err_phase;
      pslverr |-> psel && penable;
   endproperty
   a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
   property p_ninth;
      !uart1_mode[1] |-> !uart1_tx_ninth;
   endproperty
   a_ninth: assert property (p_ninth) else $error("ninth bit sent in 8-bit mode");
   property p_rate0;
      uart0_rate_x2 |-> uart0_mode == 2'b10 || (uart0_mode[0] && uart0_timer1_src);
   endproperty
   a_rate0: assert property (p_rate0) else $error("port 0 doubled in wrong mode");
   property p_svc_set;
      $rose(uart1_service_req) |-> $past(tx1_frame_done || rx1_frame_done || wr);
   endproperty
   a_svc_set: assert property (p_svc_set) else $error("service request without cause");
   property p_svc_hold;
      $fell(uart1_service_req) |-> $past(wr);
   endproperty
   a_svc_hold: assert property (p_svc_hold) else $error("done flag cleared by hardware");
   property p_irq_hold;
      $fell(irq) |-> $past(wr);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without write");
   property p_m0_rate;
      uart1_baud_tick && same_r && uart1_mode == mode_r && uart1_mode == 2'b00 |-> gap_r == 7'd11;
   endproperty
   a_m0_rate: assert property (p_m0_rate) else $error("mode 0 tick spacing");
   property p_m2_rate;
      uart1_baud_tick && same_r && uart1_mode == mode_r && uart1_mode == 2'b10
         |-> gap_r == 7'd31 || gap_r == 7'd63;
   endproperty
   a_m2_rate: assert property (p_m2_rate) else $error("mode 2 tick spacing");
   property p_t3_rate;
      uart1_baud_tick && same_r && uart1_mode == mode_r && uart1_mode[0] |-> ovf_r == 5'd16;
   endproperty
   a_t3_rate: assert property (p_t3_rate) else $error("timer tick count");
endmodule
bind scf_top scf_properties u_props (.clk, .rst_n, .psel, .penable, .pwrite, .pready,
   .pslverr, .tx1_frame_done, .rx1_frame_done, .timer3_ovf, .uart0_timer1_src, .uart1_mode,
   .uart0_mode, .uart1_tx_ninth, .uart1_baud_tick, .uart1_service_req, .uart0_rate_x2, .irq);
`default_nettype wire

// >>> testbench/scf_top_test.sv
// Self-checking testbench for the serial port control flags block.
`timescale 1ns/1ps
`default_nettype none
module scf_top_test;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic tx1_frame_done, rx1_frame_done, rx1_bit9, timer3_ovf;
   logic [7:0] rx1_data;
   logic [1:0] uart1_mode, uart0_mode;
   logic uart1_rx_enable, uart1_tx_ninth, uart1_baud_tick, uart1_service_req;
   logic uart0_frame_err_evt, uart0_timer1_src, uart0_rate_x2, irq;
   logic [24:0] rows [9];
   int bad_count, tests_run, cycles;
   scf_top dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .tx1_frame_done, .rx1_frame_done, .rx1_data, .rx1_bit9, .timer3_ovf,
      .uart1_mode, .uart1_rx_enable, .uart1_tx_ninth, .uart1_baud_tick, .uart1_service_req,
      .uart0_frame_err_evt, .uart0_timer1_src, .uart0_mode, .uart0_rate_x2, .irq);
   scf_node node (.clk, .tx1_frame_done, .rx1_frame_done, .rx1_data, .rx1_bit9, .timer3_ovf,
      .uart0_frame_err_evt);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // The request is released only after pready was seen, never at the same edge it is raised.
   task automatic apb(input logic [9:0] idx, input logic w, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic reg_is(input logic [9:0] idx, input logic [31:0] exp, input string what);
      apb(idx, 1'b0, 32'h0);
      check(what, rd, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, uart0_timer1_src, cycles} = '0;
      {bad_count, tests_run} = '0;
      pstrb = 4'hf;
      rows = '{{8'hb0, 8'h5a, 1'b1, 8'hb5}, {8'hb0, 8'h33, 1'b1, 8'hb0},
         {8'hb0, 8'h5a, 1'b0, 8'hb0}, {8'h90, 8'h33, 1'b0, 8'h91}, {8'hf0, 8'h5a, 1'b1, 8'hf5},
         {8'h70, 8'h5a, 1'b1, 8'h75}, {8'h70, 8'h5a, 1'b0, 8'h70}, {8'h50, 8'h33, 1'b0, 8'h51},
         {8'h30, 8'h33, 1'b0, 8'h31}};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      reg_is(scf_pkg::IDX_POWER_CONTROL, 32'h0, "power_control");
      reg_is(scf_pkg::IDX_SERIAL1_CONTROL, 32'h0, "serial1_control");
      reg_is(scf_pkg::IDX_ADDR_CFG, 32'hff00, "addr_cfg");
      reg_is(10'h3ff, 32'h0, "unmapped");
      check("pslverr", {31'h0, err}, 32'h1);
      apb(scf_pkg::IDX_POWER_CONTROL, 1'b1, 32'hff);
      reg_is(scf_pkg::IDX_POWER_CONTROL, 32'hdf, "power_control");
      $display("test reset and access done");
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'h98);
      @(negedge clk);
      check("tx ninth mode 2", {31'h0, uart1_tx_ninth}, 32'h1);
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'h58);
      @(negedge clk);
      check("tx ninth mode 1", {31'h0, uart1_tx_ninth}, 32'h0);
      check("rx enable mode 1", {31'h0, uart1_rx_enable}, 32'h1);
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'h11);
      @(negedge clk);
      check("rx enable mode 0 done", {31'h0, uart1_rx_enable}, 32'h0);
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'h00);
      $display("test controls done");
      apb(scf_pkg::IDX_UART1_EXT, 1'b1, 32'h01);
      node.sent(1'b0);
      @(negedge clk);
      check("service request", {31'h0, uart1_service_req}, 32'h1);
      check("masked irq", {31'h0, irq}, 32'h0);
      apb(scf_pkg::IDX_IRQ_MASK, 1'b1, 32'hf);
      repeat (20) @(posedge clk);
      reg_is(scf_pkg::IDX_SERIAL1_CONTROL, 32'h02, "tx done kept");
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'h00);
      apb(scf_pkg::IDX_IRQ_STATUS, 1'b1, 32'hf);
      @(negedge clk);
      check("request after clear", {30'h0, uart1_service_req, irq}, 32'h0);
      $display("test interrupt done");
      apb(scf_pkg::IDX_ADDR_CFG, 1'b1, 32'h005a);
      foreach (rows[i]) begin
         apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, {24'h0, rows[i][24:17]});
         node.send(rows[i][16:9], rows[i][8]);
         reg_is(scf_pkg::IDX_SERIAL1_CONTROL, {24'h0, rows[i][7:0]}, "rx frame");
      end
      $display("test filter done");
      apb(scf_pkg::IDX_UART1_EXT, 1'b1, 32'h41);
      reg_is(scf_pkg::IDX_SERIAL1_CONTROL, 32'hb1, "frame err view");
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'h31);
      reg_is(scf_pkg::IDX_SERIAL1_CONTROL, 32'h31, "frame err cleared");
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'hf0);
      node.send(8'h5a, 1'b0);
      reg_is(scf_pkg::IDX_SERIAL1_CONTROL, 32'hf0, "frame err set");
      apb(scf_pkg::IDX_UART1_EXT, 1'b1, 32'h01);
      reg_is(scf_pkg::IDX_SERIAL1_CONTROL, 32'h70, "mode view");
      apb(scf_pkg::IDX_POWER_CONTROL, 1'b1, 32'h40);
      node.sent(1'b1);
      reg_is(scf_pkg::IDX_SERIAL0_VIEW, 32'h80, "port 0 frame err");
      apb(scf_pkg::IDX_POWER_CONTROL, 1'b1, 32'h00);
      apb(scf_pkg::IDX_SERIAL0_VIEW, 1'b1, 32'h80);
      apb(scf_pkg::IDX_POWER_CONTROL, 1'b1, 32'h80);
      @(negedge clk);
      check("port 0 mode 2 rate", {30'h0, uart0_mode, uart0_rate_x2}, 32'h5);
      apb(scf_pkg::IDX_SERIAL0_VIEW, 1'b1, 32'h40);
      @(negedge clk);
      check("port 0 mode 1 rate", {31'h0, uart0_rate_x2}, 32'h0);
      @(posedge clk);
      uart0_timer1_src <= 1'b1;
      @(negedge clk);
      check("port 0 timer rate", {31'h0, uart0_rate_x2}, 32'h1);
      $display("test frame error done");
      // Baud double changes only in mode 0 so no checked divider interval sees it.
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'h00);
      repeat (40) @(posedge clk);
      apb(scf_pkg::IDX_UART1_EXT, 1'b1, 32'h80);
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'h80);
      repeat (200) @(posedge clk);
      apb(scf_pkg::IDX_SERIAL1_CONTROL, 1'b1, 32'hc0);
      repeat (300) @(posedge clk);
      $display("test bit rate done");
      end_of_test();
   end
endmodule
`default_nettype wire
